// >>> include/mfi_pkg.sv
// Summary of operation
// - register zero: timer2/timer0 flags 7..4, enables 3..0
// - small variant: timer1 P flag in bit 4
// - small variant: timer1 P enable in bit 0
// - timer1 A flag in bit 5, all variants
// - timer1 A enable in bit 1
// - large variants: timer1 B flag bit 6, enable bit 2
// - unimplemented flag register bits read zero
// - eeprom flag bit 7, enable bit 3
// - low voltage flag bit 6, enable bit 2
// - external peripheral flag in bit 5
// - external peripheral enable in bit 1
// - serial module flag bit 4, enable bit 0
// - events set flags whatever the enable
// - global enable low suppresses the combined request only
// - any flag becoming set wakes the device
`default_nettype none
package mfi_pkg;
  localparam int           REG_W         = 8;
  localparam int           ADDR_W        = 3;
  // register word addresses on the plain register port
  localparam logic [2:0]   ADDR_TMR_ZERO = 3'h0;
  localparam logic [2:0]   ADDR_TMR_ONE  = 3'h1;
  localparam logic [2:0]   ADDR_MISC     = 3'h2;
  localparam logic [2:0]   ADDR_STATUS   = 3'h3;
  localparam logic [2:0]   ADDR_MASK     = 3'h4;
  // flag nibble sits above its enable nibble
  localparam int           FLAG_LSB      = 4;
  localparam int           EN_LSB        = 0;
  localparam int           NIB_W         = 4;
  // implemented-bit masks
  localparam logic [7:0]   MASK_ZERO     = 8'hff;
  localparam logic [7:0]   MASK_ONE_SML  = 8'h33;
  localparam logic [7:0]   MASK_ONE_LRG  = 8'h77;
  localparam logic [7:0]   MASK_MISC     = 8'hff;
  localparam logic [7:0]   RESET_VAL     = 8'h00;
  // local event status layout
  localparam int           EV_W          = 3;
  localparam int           EV_WAKE       = 0;
  localparam int           EV_REQ        = 1;
  localparam int           EV_SW_SET     = 2;
  localparam logic [2:0]   EV_MASK_RST   = 3'h0;
endpackage : mfi_pkg
`default_nettype wire

// >>> include/mfi_bus_if.sv
`default_nettype none
// register port between top and flag register slices
interface mfi_bus_if;
  logic [7:0] wdata;
  logic       wr;
  logic [7:0] rdata;
  modport host  (output wdata, output wr, input rdata);
  modport slice (input wdata, input wr, output rdata);
endinterface : mfi_bus_if
`default_nettype wire

// >>> logic/mfi_flag_reg.sv
`default_nettype none
// one flag/enable register: four flags high, four enables low
module mfi_flag_reg
  import mfi_pkg::*;
#(
  parameter logic [7:0] IMPL = 8'hff
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  mfi_bus_if.slice              bus,
  input  wire logic [NIB_W-1:0] event_i,
  output logic                  req_o,
  output logic                  set_o
);
  logic [7:0] val_reg;
  logic [7:0] val_next;
  logic [7:0] ev_bits;
  logic [7:0] wr_val;

  // hardware set wins over a software write of zero
  assign ev_bits  = {event_i, {NIB_W{1'b0}}} & IMPL;
  assign wr_val   = bus.wr ? (bus.wdata & IMPL) : val_reg;
  assign val_next = wr_val | ev_bits;
  assign bus.rdata = val_reg & IMPL;
  // flag and enable pair up bit for bit
  assign req_o = |(val_reg[FLAG_LSB +: NIB_W] & val_reg[EN_LSB +: NIB_W]);
  // rising flag of any source, whether from hardware or software
  assign set_o = |(val_next[FLAG_LSB +: NIB_W] & ~val_reg[FLAG_LSB +: NIB_W]);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      val_reg <= RESET_VAL;
    end else begin
      val_reg <= val_next;
    end
  end

  flag_set_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (|(event_i & IMPL[FLAG_LSB +: NIB_W])) |=>
      ((val_reg[FLAG_LSB +: NIB_W] & $past(event_i)) == $past(event_i & IMPL[7:4])))
    else $error("event did not set its flag");
  unimpl_zero_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus.rdata & ~IMPL) == 8'h00)
    else $error("unimplemented bit read nonzero");
endmodule : mfi_flag_reg
`default_nettype wire

// >>> logic/mfi_irq_flags.sv
`default_nettype none
// multi-function interrupt flag and enable registers
module mfi_irq_flags
  import mfi_pkg::*;
#(
  parameter bit LARGE = 1'b1
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [REG_W-1:0]  wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [REG_W-1:0]       rdata_o,
  input  wire logic              global_irq_enable_i,
  input  wire logic              tmr0_cmpp_i,
  input  wire logic              tmr0_cmpa_i,
  input  wire logic              tmr1_cmpp_i,
  input  wire logic              tmr1_cmpa_i,
  input  wire logic              tmr1_cmpb_i,
  input  wire logic              tmr2_cmpp_i,
  input  wire logic              tmr2_cmpa_i,
  input  wire logic              eeprom_evt_i,
  input  wire logic              low_volt_evt_i,
  input  wire logic              ext_periph_evt_i,
  input  wire logic              serial_evt_i,
  output logic                   req_zero_o,
  output logic                   req_one_o,
  output logic                   req_misc_o,
  output logic                   mfi_irq_o,
  output logic                   wake_o,
  output logic                   irq_o
);
  import mfi_pkg::*;

  localparam logic [7:0] IMPL_ONE = LARGE ? MASK_ONE_LRG : MASK_ONE_SML;

  mfi_bus_if bus_zero ();
  mfi_bus_if bus_one ();
  mfi_bus_if bus_misc ();

  logic [REG_W-1:0] rdata_reg;
  logic [REG_W-1:0] rdata_next;
  logic [EV_W-1:0]  status_reg;
  logic [EV_W-1:0]  status_next;
  logic [EV_W-1:0]  mask_reg;
  logic [EV_W-1:0]  ev_now;
  logic             req_zero;
  logic             req_one;
  logic             req_misc;
  logic             set_zero;
  logic             set_one;
  logic             set_misc;
  logic             any_req;
  logic             sw_flag_set;
  logic             wr_status;
  logic             wr_mask;

  // write decode for each register
  assign bus_zero.wr    = wr_i && (addr_i == ADDR_TMR_ZERO);
  assign bus_one.wr     = wr_i && (addr_i == ADDR_TMR_ONE);
  assign bus_misc.wr    = wr_i && (addr_i == ADDR_MISC);
  assign bus_zero.wdata = wdata_i;
  assign bus_one.wdata  = wdata_i;
  assign bus_misc.wdata = wdata_i;
  assign wr_status      = wr_i && (addr_i == ADDR_STATUS);
  assign wr_mask        = wr_i && (addr_i == ADDR_MASK);

  // register zero: timer2 A, timer2 P, timer0 A, timer0 P
  mfi_flag_reg #(.IMPL(MASK_ZERO)) u_zero (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bus       (bus_zero),
    .event_i   ({tmr2_cmpa_i, tmr2_cmpp_i, tmr0_cmpa_i, tmr0_cmpp_i}),
    .req_o     (req_zero),
    .set_o     (set_zero)
  );

  // register one: timer1 B only exists in the larger variants
  mfi_flag_reg #(.IMPL(IMPL_ONE)) u_one (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bus       (bus_one),
    .event_i   ({1'b0, tmr1_cmpb_i, tmr1_cmpa_i, tmr1_cmpp_i}),
    .req_o     (req_one),
    .set_o     (set_one)
  );

  // register two: eeprom, low voltage, external peripheral, serial
  mfi_flag_reg #(.IMPL(MASK_MISC)) u_misc (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bus       (bus_misc),
    .event_i   ({eeprom_evt_i, low_volt_evt_i, ext_periph_evt_i, serial_evt_i}),
    .req_o     (req_misc),
    .set_o     (set_misc)
  );

  // requests and wake-up
  assign req_zero_o  = req_zero;
  assign req_one_o   = req_one;
  assign req_misc_o  = req_misc;
  assign any_req     = req_zero | req_one | req_misc;
  assign mfi_irq_o   = global_irq_enable_i & any_req;
  // wake follows a rising flag, not the enables, so flags set before sleep never wake
  assign wake_o      = set_zero | set_one | set_misc;
  assign sw_flag_set = wake_o & wr_i;

  // local event status: set wins over write-one-to-clear
  assign ev_now      = {sw_flag_set, mfi_irq_o, wake_o};
  assign status_next = (wr_status ? (status_reg & ~wdata_i[EV_W-1:0]) : status_reg) | ev_now;
  assign irq_o       = |(status_reg & mask_reg);

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    case (addr_i)
      ADDR_TMR_ZERO: rdata_next = bus_zero.rdata;
      ADDR_TMR_ONE:  rdata_next = bus_one.rdata;
      ADDR_MISC:     rdata_next = bus_misc.rdata;
      ADDR_STATUS:   rdata_next = {5'h00, status_reg};
      ADDR_MASK:     rdata_next = {5'h00, mask_reg};
      default:       rdata_next = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd_i ? rdata_next : 8'h00;
    end
  end
  assign rdata_o = rdata_reg;

  // status and mask registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status_reg <= EV_MASK_RST;
      mask_reg   <= EV_MASK_RST;
    end else begin
      status_reg <= status_next;
      if (wr_mask) begin
        mask_reg <= wdata_i[EV_W-1:0];
      end
    end
  end

  sequence s_rd_one;
    rd_i && (addr_i == ADDR_TMR_ONE);
  endsequence
  sequence s_rd_misc;
    rd_i && (addr_i == ADDR_MISC);
  endsequence

  gie_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !global_irq_enable_i |-> !mfi_irq_o)
    else $error("request passed with global enable low");
  req_combine_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_misc.rdata[7] && bus_misc.rdata[3] && global_irq_enable_i) |-> mfi_irq_o)
    else $error("eeprom request not combined");
  one_unimpl_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_rd_one |=> (rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0))
    else $error("timer1 unimplemented bits nonzero");
  tmr1_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tmr1_cmpa_i && !wr_i) ##1 s_rd_one |=> rdata_o[5])
    else $error("timer1 A flag not seen");
  tmr1_small_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !LARGE |-> !bus_one.rdata[6] && !bus_one.rdata[2])
    else $error("small variant shows B bits");
  lv_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (low_volt_evt_i && !wr_i) ##1 s_rd_misc |=> rdata_o[6])
    else $error("low voltage flag not seen");
  wake_evt_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (serial_evt_i && !bus_misc.rdata[4]) |-> wake_o)
    else $error("serial flag did not wake");
  rst_clear_a: assert property (@(posedge sys_clk_i)
    rst_i |=> (bus_zero.rdata == 8'h00 && status_reg == 3'h0))
    else $error("reset did not clear flags");
  status_sticky_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wake_o && wr_status) |=> status_reg[EV_WAKE])
    else $error("clear beat a wake event");
endmodule : mfi_irq_flags
`default_nettype wire

// >>> sim/mfi_src_model.sv
`default_nettype none
// event sources beside the core: each request leaves one cycle after fire_i, for as long as fire_i holds
module mfi_src_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [10:0] fire_i,
  output logic      [10:0] evt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // registered, so each pulse lasts as long as fire_i holds, one cycle later
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) evt_o <= 11'h000;
    else evt_o <= fire_i;
  end
endmodule : mfi_src_model
`default_nettype wire

// >>> sim/mfi_irq_flags_tb_top.sv
`default_nettype none
module mfi_irq_flags_tb_top;
  import mfi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i, rst_i, wr_i, rd_i, gie;
  logic [2:0]  addr_i;
  logic [7:0]  wdata_i, rdata_o;
  logic [7:0]  rdata_s;
  logic [10:0] fire, evt;
  logic        rz, r1, rm, mfi, wake, irq;
  int          errors, checks_done;
  // register and bit of each event line, in fire order
  int          ra[11] = '{0, 0, 1, 1, 1, 0, 0, 2, 2, 2, 2};
  int          rb[11] = '{4, 5, 4, 5, 6, 6, 7, 7, 6, 5, 4};

  mfi_src_model SRC (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .fire_i(fire), .evt_o(evt));
  mfi_irq_flags #(.LARGE(1'b1)) DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .global_irq_enable_i(gie),
    .tmr0_cmpp_i(evt[0]), .tmr0_cmpa_i(evt[1]), .tmr1_cmpp_i(evt[2]),
    .tmr1_cmpa_i(evt[3]), .tmr1_cmpb_i(evt[4]), .tmr2_cmpp_i(evt[5]),
    .tmr2_cmpa_i(evt[6]), .eeprom_evt_i(evt[7]), .low_volt_evt_i(evt[8]),
    .ext_periph_evt_i(evt[9]), .serial_evt_i(evt[10]), .req_zero_o(rz),
    .req_one_o(r1), .req_misc_o(rm), .mfi_irq_o(mfi), .wake_o(wake), .irq_o(irq));
  // smallest variant on the same bus: only its register one read is compared
  mfi_irq_flags #(.LARGE(1'b0)) DUT_SML (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_s), .global_irq_enable_i(gie),
    .tmr0_cmpp_i(evt[0]), .tmr0_cmpa_i(evt[1]), .tmr1_cmpp_i(evt[2]),
    .tmr1_cmpa_i(evt[3]), .tmr1_cmpb_i(evt[4]), .tmr2_cmpp_i(evt[5]),
    .tmr2_cmpa_i(evt[6]), .eeprom_evt_i(evt[7]), .low_volt_evt_i(evt[8]),
    .ext_periph_evt_i(evt[9]), .serial_evt_i(evt[10]), .req_zero_o(),
    .req_one_o(), .req_misc_o(), .mfi_irq_o(), .wake_o(), .irq_o());

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rc(input string n, input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1 chk(n, rdata_o, e);
  endtask : rc

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    {rst_i, wr_i, rd_i, addr_i, wdata_i, fire, gie} = {1'b1, 25'h0};
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) rc("reset", 3'(a), 8'h00);
    $display("test reset done");
    // all ones show implemented bits only; holes read zero
    wr(ADDR_TMR_ZERO, 8'hff);
    rc("reg zero", ADDR_TMR_ZERO, 8'hff);
    wr(ADDR_TMR_ONE, 8'hff);
    rc("reg one", ADDR_TMR_ONE, 8'h77);
    chk("reg one small", rdata_s, 8'h33);
    wr(ADDR_MISC, 8'hff);
    rc("reg misc", ADDR_MISC, 8'hff);
    wr(3'h5, 8'hff);
    rc("hole", 3'h5, 8'h00);
    chk("reqs", {5'h0, rz, r1, rm}, 8'h07);
    chk("gated", 8'(mfi), 8'h00);
    @(posedge sys_clk_i);
    gie <= 1'b1;
    @(posedge sys_clk_i);
    #1 chk("mfi", 8'(mfi), 8'h01);
    for (int a = 0; a < 3; a++) wr(3'(a), 8'h00);
    #1 chk("cleared", {4'h0, mfi, rz, r1, rm}, 8'h00);
    $display("test access done");
    // each event sets its own flag with its enable low
    for (int i = 0; i < 11; i++) begin
      @(posedge sys_clk_i);
      fire <= 11'(1) << i;
      @(posedge sys_clk_i);
      fire <= '0;
      #1 chk("wake", 8'(wake), 8'h01);
      rc("event", 3'(ra[i]), 8'h01 << rb[i]);
      chk("no req", {4'h0, mfi, rz, r1, rm}, 8'h00);
      wr(3'(ra[i]), 8'h00);
    end
    $display("test events done");
    // interrupt status: raise, mask, unmask, clear by writing one
    wr(ADDR_STATUS, 8'h07);
    rc("status", ADDR_STATUS, 8'h00);
    wr(ADDR_MASK, 8'h01);
    chk("irq idle", 8'(irq), 8'h00);
    @(posedge sys_clk_i);
    fire <= 11'h010;
    @(posedge sys_clk_i);
    fire <= '0;
    rc("status", ADDR_STATUS, 8'h01);
    chk("irq set", 8'(irq), 8'h01);
    wr(ADDR_MASK, 8'h00);
    #1 chk("irq mask", 8'(irq), 8'h00);
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    #1 chk("irq clr", 8'(irq), 8'h00);
    rc("status", ADDR_STATUS, 8'h00);
    $display("test interrupt done");
    wrap_up();
  end

  // cuts a hang short
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    errors++;
    wrap_up();
  end
endmodule : mfi_irq_flags_tb_top
`default_nettype wire
